// ===== logic/srm_pkg.sv
// Constants, types and setup list for the ring master sequencer.
// Assumes one 25 MHz clock and an AXI4-Lite master on the register side.
package srm_pkg;
	localparam int NRING = 2;
	localparam int NSLV = 8;
	localparam int QDEPTH = 16;
	localparam int ADDR_W = 7;
	localparam int RING_BIT = 6;
	localparam int CLK_MHZ = 25;
	localparam int CYC_TIME_US = 1000;
	localparam int CYC_CYC = CYC_TIME_US * CLK_MHZ;
	localparam int AT_TMO_US = 800;
	localparam int AT_TMO_CYC = AT_TMO_US * CLK_MHZ;

	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_RESUME = 6'h04;
	localparam logic [5:0] OFS_PHASE = 6'h08;
	localparam logic [5:0] OFS_ERR = 6'h0c;
	localparam logic [5:0] OFS_TTYPE = 6'h10;
	localparam logic [5:0] OFS_SEL = 6'h14;
	localparam logic [5:0] OFS_CBITS = 6'h18;
	localparam logic [5:0] OFS_STAT = 6'h1c;
	localparam logic [5:0] OFS_CMD = 6'h20;
	localparam logic [5:0] OFS_FB = 6'h24;
	localparam logic [5:0] OFS_SVREQ = 6'h28;
	localparam logic [5:0] OFS_SVDATA = 6'h2c;
	localparam logic [5:0] OFS_SVSTAT = 6'h30;
	localparam logic [5:0] OFS_HOME = 6'h34;

	localparam int CTL_START = 0;
	localparam int CTL_HALT = 1;
	localparam int CTL_MOTION = 2;
	localparam int CTL_NSLV = 4;
	localparam logic [31:0] CTL_RST = 32'h0000_0070;
	localparam logic [2:0] TT_RST = 3'h4;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [2:0] TT_POS = 3'h4;
	localparam logic [15:0] MODE_POS = 16'h0003;
	localparam int ERR_AT = 0;
	localparam int ERR_RX = 1;
	localparam int ERR_OVF = 2;
	localparam int ERR_OVR = 3;
	localparam int CB_HOME = 14;
	localparam int CB_HACK = 13;
	localparam logic [1:0] TK_MST = 2'h0;
	localparam logic [1:0] TK_MDT = 2'h1;

	localparam logic [4:0] SIDX_FIRST_WR = 5'h06;
	localparam logic [4:0] SIDX_HALT = 5'h0f;
	localparam logic [4:0] SIDX_P3 = 5'h10;
	localparam logic [4:0] SIDX_LAST = 5'h11;
	localparam logic [15:0] IDN_CYC_NC = 16'h0001;
	localparam logic [15:0] IDN_CYC_SC = 16'h0002;
	localparam logic [15:0] IDN_TTYPE = 16'h000f;
	localparam logic [15:0] IDN_PMODE = 16'h0020;
	localparam logic [15:0] SETUP_IDN [0:17] = '{
		16'h0003, 16'h0004, 16'h0005, 16'h0058, 16'h005a, 16'h0060,
		16'h0001, 16'h0002, 16'h0006, 16'h0007, 16'h0009, 16'h000a,
		16'h000f, 16'h0020, 16'h0059, 16'h0063, 16'h007f, 16'h0080};

	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_MST = 2'b01,
		RS_AT = 2'b11,
		RS_MDT = 2'b10
	} srm_rstate_t;

	typedef struct packed {
		logic [1:0] kind;
		logic last;
		logic [2:0] slave;
		logic [15:0] ctrl;
		logic [15:0] svc;
		logic [31:0] cyc;
	} srm_tx_t;

	typedef struct packed {
		logic [2:0] slave;
		logic [15:0] stat;
		logic [15:0] svc;
		logic [31:0] cyc;
		logic err;
	} srm_rx_t;

	typedef struct packed {
		logic wr;
		logic [2:0] slv;
		logic [15:0] idn;
		logic [31:0] data;
	} srm_svreq_t;
endpackage : srm_pkg

// ===== logic/srm_ring_master.sv
// Two-ring master sequencer: cycle timing, phase setup, service channel.
// Assumes link framers on mclk that take telegram items and return replies.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module srm_ring_master
	import srm_pkg::*;
#(
	parameter int CYC_CYCLES = CYC_CYC,
	parameter int AT_TMO_CYCLES = AT_TMO_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output wire logic [NRING-1:0] tx_valid,
	input wire logic [NRING-1:0] tx_ready,
	output wire srm_tx_t [NRING-1:0] tx_tel,
	input wire logic [NRING-1:0] rx_valid,
	input wire srm_rx_t [NRING-1:0] rx_tel
);
	function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
		reg_ok = (a[5:0] <= OFS_HOME) && (a[1:0] == 2'b00);
	endfunction : reg_ok

	function automatic logic [31:0] setup_data(input logic [15:0] idn,
			input logic [2:0] tt, input logic [15:0] md);
		setup_data = 32'h0;
		if (idn == IDN_TTYPE)
			setup_data = {29'h0, tt};
		else if (idn == IDN_PMODE)
			setup_data = {16'h0, md};
		else if (idn == IDN_CYC_NC || idn == IDN_CYC_SC)
			setup_data = 32'(CYC_TIME_US);
	endfunction : setup_data

	logic aw_got_r, w_got_r;
	logic [ADDR_W-1:0] aw_a_r;
	logic [31:0] w_d_r;
	logic wr_en;
	logic [31:0] rd_val [NRING];
	logic [31:0] div_r;
	logic tick;

	assign s_axi_awready = !aw_got_r;
	assign s_axi_wready = !w_got_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_en = aw_got_r && w_got_r && !s_axi_bvalid;

	// Address and data may arrive in either order; the write lands once both are held
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_a_r <= '0;
			w_d_r <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_got_r) begin
				aw_got_r <= 1'b1;
				aw_a_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_r) begin
				w_got_r <= 1'b1;
				w_d_r <= s_axi_wdata;
			end
			if (wr_en) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_ok(aw_a_r) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= reg_ok(s_axi_araddr) ? rd_val[s_axi_araddr[RING_BIT]] : 32'h0;
			s_axi_rresp <= reg_ok(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Shared cycle timer keeps both rings on one cycle grid
	assign tick = (div_r == 32'(CYC_CYCLES - 1));
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			div_r <= 32'h0;
		else
			div_r <= tick ? 32'h0 : div_r + 32'h1;
	end

	for (genvar g = 0; g < NRING; g++) begin : rg
		logic we;
		logic [5:0] wo;
		logic [5:0] ro;
		logic [31:0] ctl_r;
		logic [2:0] tt_r;
		logic [15:0] mode_r;
		logic [2:0] sel_r;
		logic [15:0] cbit_r [NSLV];
		logic [15:0] stat_r [NSLV];
		logic [31:0] cmd_r [NSLV];
		logic [31:0] fb_r [NSLV];
		logic [NSLV-1:0] home_r, hack_r;
		logic [3:0] err_r;
		logic [2:0] cur_r, done_r;
		logic done_v_r, halt_r, bad_r, pend_r;
		logic [4:0] sidx_r;
		logic [2:0] sslv_r;
		logic [31:0] swd_r, srd_r, cap_r;
		logic sdone_r, sv_sw_r;
		logic [1:0] sv_step_r;
		srm_svreq_t sv_r;
		srm_svreq_t q_r [QDEPTH];
		logic [$clog2(QDEPTH)-1:0] qh_r, qt_r;
		logic [$clog2(QDEPTH):0] qn_r;
		srm_rstate_t st_r;
		logic [2:0] md_r;
		logic [NSLV-1:0] seen_r, seen_nxt, all_m;
		logic [31:0] tmo_r;
		logic cyc_done, phase4, setup_go, q_go, launch, push;
		logic [2:0] nslv, tt_eff;
		logic [15:0] mode_eff, svc_w;
		srm_svreq_t sreq;

		assign we = wr_en && (int'(aw_a_r[RING_BIT]) == g);
		assign wo = aw_a_r[5:0];
		assign ro = s_axi_araddr[5:0];
		assign nslv = ctl_r[CTL_NSLV +: 3];
		assign all_m = 8'hff >> (3'd7 - nslv);
		assign tt_eff = ctl_r[CTL_MOTION] ? TT_POS : tt_r;
		assign mode_eff = ctl_r[CTL_MOTION] ? MODE_POS : mode_r;
		assign phase4 = done_v_r && (done_r == 3'd4);
		assign seen_nxt = seen_r | (rx_valid[g] ? 8'(8'h01 << rx_tel[g].slave) : 8'h0);
		assign cyc_done = (st_r == RS_MDT) && tx_ready[g] && (md_r == nslv);
		assign push = we && (wo == OFS_SVREQ) && (qn_r != 5'(QDEPTH));

		// Slot order inside a cycle is fixed by this state walk
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				st_r <= RS_IDLE;
				md_r <= 3'h0;
				seen_r <= '0;
				tmo_r <= 32'h0;
				bad_r <= 1'b0;
			end else begin
				case (st_r)
					RS_IDLE: begin
						if (pend_r && ctl_r[CTL_START])
							st_r <= RS_MST;
					end
					RS_MST: begin
						if (tx_ready[g]) begin
							st_r <= RS_AT;
							seen_r <= '0;
							tmo_r <= 32'h0;
							bad_r <= 1'b0;
						end
					end
					RS_AT: begin
						seen_r <= seen_nxt;
						tmo_r <= tmo_r + 32'h1;
						if ((seen_nxt & all_m) == all_m) begin
							st_r <= RS_MDT;
							md_r <= 3'h0;
						end else if (tmo_r == 32'(AT_TMO_CYCLES - 1)) begin
							st_r <= RS_MDT;
							md_r <= 3'h0;
							bad_r <= 1'b1;
						end
					end
					RS_MDT: begin
						if (tx_ready[g]) begin
							if (md_r == nslv)
								st_r <= RS_IDLE;
							else
								md_r <= md_r + 3'h1;
						end
					end
					default: st_r <= RS_IDLE;
				endcase
			end
		end

		always_comb begin
			svc_w = 16'h0;
			if (sv_step_r != 2'h0 && sv_r.slv == md_r) begin
				case (sv_step_r)
					2'h1: svc_w = sv_r.idn;
					2'h2: svc_w = sv_r.wr ? sv_r.data[15:0] : 16'h0;
					2'h3: svc_w = sv_r.wr ? sv_r.data[31:16] : 16'h0;
					default: svc_w = 16'h0;
				endcase
			end
		end

		assign tx_valid[g] = (st_r == RS_MST) || (st_r == RS_MDT);
		assign tx_tel[g].kind = (st_r == RS_MST) ? TK_MST : TK_MDT;
		assign tx_tel[g].last = (st_r == RS_MST) || (md_r == nslv);
		assign tx_tel[g].slave = md_r;
		assign tx_tel[g].ctrl = cbit_r[md_r] | (16'(home_r[md_r]) << CB_HOME)
			| (16'(hack_r[md_r]) << CB_HACK);
		assign tx_tel[g].svc = svc_w;
		assign tx_tel[g].cyc = phase4 ? cmd_r[md_r] : 32'h0;

		// Replies are only taken in the amplifier window, so stray words are dropped
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				for (int i = 0; i < NSLV; i++) begin
					stat_r[i] <= 16'h0;
					fb_r[i] <= 32'h0;
				end
				cap_r <= 32'h0;
			end else if (st_r == RS_AT && rx_valid[g]) begin
				stat_r[rx_tel[g].slave] <= rx_tel[g].stat;
				if (phase4)
					fb_r[rx_tel[g].slave] <= rx_tel[g].cyc;
				if (rx_tel[g].slave == sv_r.slv && sv_step_r == 2'h2)
					cap_r[15:0] <= rx_tel[g].svc;
				if (rx_tel[g].slave == sv_r.slv && sv_step_r == 2'h3)
					cap_r[31:16] <= rx_tel[g].svc;
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				ctl_r <= CTL_RST;
				tt_r <= TT_RST;
				mode_r <= MODE_RST;
				sel_r <= 3'h0;
				swd_r <= 32'h0;
				home_r <= '0;
				hack_r <= '0;
				for (int i = 0; i < NSLV; i++) begin
					cbit_r[i] <= 16'h0;
					cmd_r[i] <= 32'h0;
				end
			end else if (we) begin
				case (wo)
					OFS_CTRL: ctl_r <= w_d_r;
					OFS_TTYPE: begin
						tt_r <= w_d_r[2:0];
						mode_r <= w_d_r[31:16];
					end
					OFS_SEL: sel_r <= w_d_r[2:0];
					OFS_CBITS: cbit_r[sel_r] <= w_d_r[15:0];
					OFS_CMD: cmd_r[sel_r] <= w_d_r;
					OFS_SVDATA: swd_r <= w_d_r;
					OFS_HOME: begin
						home_r[sel_r] <= w_d_r[0];
						hack_r[sel_r] <= w_d_r[1];
					end
					default: ;
				endcase
			end
		end

		// Hardware set wins over a software clear in the same cycle
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				err_r <= 4'h0;
				pend_r <= 1'b0;
			end else begin
				err_r <= (err_r & ~((we && wo == OFS_ERR) ? w_d_r[3:0] : 4'h0))
					| (4'(bad_r && cyc_done) << ERR_AT)
					| (4'(rx_valid[g] && rx_tel[g].err) << ERR_RX)
					| (4'(we && wo == OFS_SVREQ && !push) << ERR_OVF)
					| (4'(tick && pend_r) << ERR_OVR);
				if (tick)
					pend_r <= 1'b1;
				else if (st_r == RS_IDLE && ctl_r[CTL_START])
					pend_r <= 1'b0;
			end
		end

		// Setup list runs before queued software requests
		assign setup_go = ctl_r[CTL_START] && ((cur_r == 3'd2 && !halt_r)
			|| (cur_r == 3'd3 && sidx_r == SIDX_LAST));
		assign q_go = (qn_r != '0) && done_v_r && (done_r >= 3'd2);
		assign launch = (sv_step_r == 2'h0) && (st_r == RS_IDLE) && (setup_go || q_go);
		assign sreq.wr = (sidx_r >= SIDX_FIRST_WR) && (sidx_r <= SIDX_HALT);
		assign sreq.slv = sslv_r;
		assign sreq.idn = SETUP_IDN[sidx_r];
		assign sreq.data = setup_data(SETUP_IDN[sidx_r], tt_eff, mode_eff);

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				qh_r <= '0;
				qt_r <= '0;
				qn_r <= '0;
				for (int i = 0; i < QDEPTH; i++)
					q_r[i] <= '0;
			end else begin
				if (push) begin
					q_r[qt_r] <= '{wr: w_d_r[31], slv: w_d_r[30:28],
						idn: w_d_r[15:0], data: swd_r};
					qt_r <= qt_r + 1'b1;
				end
				if (launch && !setup_go)
					qh_r <= qh_r + 1'b1;
				qn_r <= qn_r + (push ? 1'b1 : 1'b0) - ((launch && !setup_go) ? 1'b1 : 1'b0);
			end
		end

		// One request in flight; header, low and high words take one cycle each
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				sv_step_r <= 2'h0;
				sv_r <= '0;
				sv_sw_r <= 1'b0;
				srd_r <= 32'h0;
				sdone_r <= 1'b0;
			end else begin
				if (we && wo == OFS_SVSTAT && w_d_r[0])
					sdone_r <= 1'b0;
				if (launch) begin
					sv_step_r <= 2'h1;
					sv_r <= setup_go ? sreq : q_r[qh_r];
					sv_sw_r <= !setup_go;
				end else if (cyc_done && sv_step_r != 2'h0) begin
					sv_step_r <= sv_step_r + 2'h1;
					if (sv_step_r == 2'h3 && sv_sw_r) begin
						sdone_r <= 1'b1;
						srd_r <= cap_r;
					end
				end
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				cur_r <= 3'd0;
				done_r <= 3'd0;
				done_v_r <= 1'b0;
				halt_r <= 1'b0;
				sidx_r <= 5'h0;
				sslv_r <= 3'h0;
			end else begin
				if (we && wo == OFS_RESUME)
					halt_r <= 1'b0;
				if (cyc_done && !bad_r && (cur_r <= 3'd1 || cur_r == 3'd4)
						&& !(done_v_r && done_r == cur_r)) begin
					done_r <= cur_r;
					done_v_r <= 1'b1;
					if (cur_r != 3'd4)
						cur_r <= cur_r + 3'd1;
				end
				if (cyc_done && sv_step_r == 2'h3 && !sv_sw_r) begin
					if (sslv_r != nslv) begin
						sslv_r <= sslv_r + 3'h1;
					end else begin
						sslv_r <= 3'h0;
						sidx_r <= sidx_r + 5'h1;
						if (sidx_r == SIDX_HALT) begin
							done_r <= 3'd2;
							halt_r <= ctl_r[CTL_HALT];
						end
						if (sidx_r == SIDX_P3)
							cur_r <= 3'd3;
						if (sidx_r == SIDX_LAST) begin
							cur_r <= 3'd4;
							done_r <= 3'd3;
						end
					end
				end
			end
		end

		always_comb begin
			case (ro)
				OFS_CTRL: rd_val[g] = ctl_r;
				OFS_PHASE: rd_val[g] = {25'h0, cur_r, done_v_r, done_r};
				OFS_ERR: rd_val[g] = {28'h0, err_r};
				OFS_TTYPE: rd_val[g] = {mode_eff, 13'h0, tt_eff};
				OFS_SEL: rd_val[g] = {29'h0, sel_r};
				OFS_CBITS: rd_val[g] = {16'h0, cbit_r[sel_r]};
				OFS_STAT: rd_val[g] = {16'h0, stat_r[sel_r]};
				OFS_CMD: rd_val[g] = cmd_r[sel_r];
				OFS_FB: rd_val[g] = fb_r[sel_r];
				OFS_SVDATA: rd_val[g] = srd_r;
				OFS_SVSTAT: rd_val[g] = {19'h0, 5'(qn_r), 6'h0,
					sv_step_r != 2'h0, sdone_r};
				OFS_HOME: rd_val[g] = {30'h0, hack_r[sel_r], home_r[sel_r]};
				default: rd_val[g] = 32'h0;
			endcase
		end
	end
endmodule : srm_ring_master
`default_nettype wire

// ===== tb/srm_ring_master_checker.sv
// Checker for the ring master: bus answers, telegram hold and cycle order.
// Assumes it is bound onto srm_ring_master; cycle order is traced on ring 0.
`timescale 1ns/100ps
`default_nettype none
module srm_ring_master_checker
	import srm_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [NRING-1:0] tx_valid,
	input wire logic [NRING-1:0] tx_ready,
	input wire srm_tx_t [NRING-1:0] tx_tel
);
	logic win_r;
	wire logic mst0 = tx_valid[0] && tx_tel[0].kind == TK_MST;
	wire logic mdt0 = tx_valid[0] && tx_tel[0].kind == TK_MDT;
	// Window runs from sync taken to the last master data item taken
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			win_r <= 1'b0;
		end else if (mst0 && tx_ready[0]) begin
			win_r <= 1'b1;
		end else if (mdt0 && tx_ready[0] && tx_tel[0].last) begin
			win_r <= 1'b0;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_mdt_in_cycle: assert property (mdt0 |-> win_r)
		else $error("master data outside cycle");
	a_sync_first: assert property (mst0 |-> !win_r)
		else $error("sync inside cycle");
	a_tel_hold0: assert property (tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_tel[0]))
		else $error("ring 0 item dropped");
	a_tel_hold1: assert property (tx_valid[1] && !tx_ready[1] |=> tx_valid[1] && $stable(tx_tel[1]))
		else $error("ring 1 item dropped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// Both halves held at one edge, write lands at the next, bvalid seen at the one after
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5:0] > 6'h34
		|=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
	c_last_mdt: cover property (mdt0 && tx_ready[0] && tx_tel[0].last);
	c_sync1: cover property (tx_valid[1] && tx_ready[1] && tx_tel[1].kind == TK_MST);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : srm_ring_master_checker
bind srm_ring_master srm_ring_master_checker u_chk (.mclk, .arst_n, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.s_axi_rresp, .tx_valid, .tx_ready, .tx_tel);
`default_nettype wire

// ===== tb/srm_drive_ring.sv
// Model of the drives on one ring, and the bench top that drives the master.
// Assumes the master link signals on mclk; stalls master items at random.
`timescale 1ns/100ps
`default_nettype none
module srm_drive_ring
	import srm_pkg::*;
#(
	parameter int NANS = 1,
	parameter int DLY = 2,
	parameter logic [15:0] SEED = 16'h1d2b
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire srm_tx_t tx_tel,
	output logic rx_valid,
	output var srm_rx_t rx_tel
);
	logic [15:0] lf_r;
	logic [15:0] ctl_m [NSLV];
	logic [15:0] svc_m [NSLV];
	logic [31:0] cyc_m [NSLV];
	logic [3:0] ans_r;
	logic [3:0] dly_r;
	logic act_r;
	logic [2:0] s;

	assign s = ans_r[2:0];

	// Random stalls make the master hold each item until it is taken
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lf_r <= SEED;
			tx_ready <= 1'b0;
		end else begin
			lf_r <= {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
			tx_ready <= lf_r[0] | lf_r[1];
		end
	end

	// Each drive keeps the last words addressed to it by slave number
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NSLV; i++) begin
				ctl_m[i] <= 16'h0;
				svc_m[i] <= 16'h0;
				cyc_m[i] <= 32'h0;
			end
		end else if (tx_valid && tx_ready && tx_tel.kind == TK_MDT) begin
			ctl_m[tx_tel.slave] <= tx_tel.ctrl;
			svc_m[tx_tel.slave] <= tx_tel.svc;
			cyc_m[tx_tel.slave] <= tx_tel.cyc;
		end
	end

	// Status echoes control, service word is scrambled, feedback is command plus one
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_r <= 1'b0;
			dly_r <= 4'h0;
			ans_r <= 4'h0;
			rx_valid <= 1'b0;
			rx_tel <= '0;
		end else begin
			rx_valid <= 1'b0;
			if (tx_valid && tx_ready && tx_tel.kind == TK_MST) begin
				act_r <= 1'b1;
				dly_r <= 4'(DLY);
				ans_r <= 4'h0;
			end else if (act_r && dly_r != 4'h0) begin
				dly_r <= dly_r - 4'h1;
			end else if (act_r) begin
				rx_valid <= 1'b1;
				rx_tel.slave <= s;
				rx_tel.stat <= ctl_m[s];
				rx_tel.svc <= svc_m[s] ^ 16'h5a5a;
				rx_tel.cyc <= cyc_m[s] + 32'h1;
				rx_tel.err <= 1'b0;
				ans_r <= ans_r + 4'h1;
				if (int'(ans_r) == NANS - 1)
					act_r <= 1'b0;
			end
		end
	end
endmodule : srm_drive_ring

`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module srm_ring_master_tb
	import srm_pkg::*;
;
	localparam int LIM = 2000;
	logic mclk;
	logic arst_n;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_last, rnd_r, cmd_v;
	logic [15:0] cb_v;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NRING-1:0] tx_valid, tx_ready, rx_valid;
	srm_tx_t [NRING-1:0] tx_tel;
	srm_rx_t [NRING-1:0] rx_tel;
	logic [32:0] exp_q [$];
	logic [32:0] note;
	int n_fail = 0;
	int samples_checked = 0;

	srm_ring_master #(.CYC_CYCLES(100), .AT_TMO_CYCLES(50)) dut (.mclk(mclk), .arst_n(arst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_tel(tx_tel),
		.rx_valid(rx_valid), .rx_tel(rx_tel));
	srm_drive_ring #(.NANS(1)) u_ring0 (.mclk(mclk), .arst_n(arst_n), .tx_valid(tx_valid[0]),
		.tx_ready(tx_ready[0]), .tx_tel(tx_tel[0]), .rx_valid(rx_valid[0]), .rx_tel(rx_tel[0]));
	srm_drive_ring #(.NANS(2), .SEED(16'h3c61)) u_ring1 (.mclk(mclk), .arst_n(arst_n),
		.tx_valid(tx_valid[1]), .tx_ready(tx_ready[1]), .tx_tel(tx_tel[1]),
		.rx_valid(rx_valid[1]), .rx_tel(rx_tel[1]));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready) && n < LIM);
		if (n >= LIM)
			n_fail++;
	endtask : axi_write

	task automatic axi_read(input logic [ADDR_W-1:0] a, input logic chk, input logic [31:0] e);
		int n;
		n = 0;
		exp_q.push_back({chk, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready) && n < LIM);
		rd_last = s_axi_rdata;
		if (n >= LIM)
			n_fail++;
	endtask : axi_read

	task automatic poll(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		do begin
			axi_read(a, 1'b0, 32'h0);
			repeat (20) @(posedge mclk);
			k++;
		end while ((rd_last & m) != v && k < 3000);
		if (k >= 3000)
			n_fail++;
	endtask : poll

	// Read data is taken at the edge where rvalid and rready are both high
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[32])
				`CHK(s_axi_rdata, note[31:0])
		end
	end

	initial begin
		repeat (95000) @(posedge mclk);
		n_fail++;
		end_of_test();
	end

	initial begin
		arst_n = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		rnd_r = 32'h6eda;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		axi_read(7'h00, 1'b1, CTL_RST);
		axi_read(7'h38, 1'b1, 32'h0);
		axi_write(7'h00, 32'h0000_0007);
		axi_write(7'h40, 32'h0000_0015);
		axi_read(7'h10, 1'b1, {MODE_POS, 13'h0, TT_POS});
		poll(7'h08, 32'h0000_000f, 32'h0000_000a);
		repeat (500) @(posedge mclk);
		axi_read(7'h08, 1'b1, 32'h0000_002a);
		axi_write(7'h28, 32'h0000_0123);
		poll(7'h30, 32'h0000_0001, 32'h0000_0001);
		axi_read(7'h2c, 1'b1, 32'h5a5a_5b79);
		axi_write(7'h04, 32'h0000_0001);
		poll(7'h08, 32'h0000_007f, 32'h0000_004c);
		poll(7'h48, 32'h0000_007f, 32'h0000_004c);
		rnd_r = xs(rnd_r);
		cmd_v = rnd_r;
		rnd_r = xs(rnd_r);
		cb_v = rnd_r[15:0];
		axi_write(7'h20, cmd_v);
		axi_write(7'h18, {16'h0, cb_v});
		axi_write(7'h34, 32'h0000_0003);
		repeat (400) @(posedge mclk);
		axi_read(7'h24, 1'b1, cmd_v + 32'h1);
		axi_read(7'h1c, 1'b1, {16'h0, cb_v | 16'h6000});
		axi_read(7'h0c, 1'b1, 32'h0);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		axi_read(7'h00, 1'b1, CTL_RST);
		axi_read(7'h08, 1'b1, 32'h0);
		repeat (2) @(posedge mclk);
		if (exp_q.size() != 0)
			n_fail++;
		end_of_test();
	end
endmodule : srm_ring_master_tb
`default_nettype wire
